/* File: pcc_cfg.svh */
// constants for the pc card / true ide host pin block
// Operation
// RL1: i/o mode irq pin pulses low or holds low, chosen by option bit.
// RL2: true ide interrupt request is driven active high.
// RL3: i/o mode input acknowledge goes low while answering a selected i/o read.
// RL4: true ide dma request is raised whenever the card is ready for dma data.
// RL5: true ide cable select low means master, high means slave; ignored elsewhere.
// RL6: memory and i/o modes pull wait low until the current cycle may finish.
// RL7: true ide drives wait low while not ready, otherwise floats it.
// RL8: first voltage sense pin is driven low, second is left floating, always.
// RL9: word access puts odd byte on upper lane, even byte on lower lane.
// RL10: true ide task file accesses use the low lane; data moves as words.
// RL11: memory and i/o modes decode all eleven address lines with register select.
// RL12: true ide decodes only the three low address lines for the task file.
// RL13: battery detect pins high in memory mode, audio pin high in i/o mode.
// RL14: i/o mode status change pin goes low on ready or protect change, if enabled.
// RL15: a true ide slave asserts diagnostic done toward the master when finished.
// RL16: true ide activity pin shows drive activity or slave presence.
// RL17: the host answers dma request with dma acknowledge for each transfer.
// RL18: register select low reaches attribute space, high reaches common memory.
// RL19: true ide chip select 0 reaches task file, 1 reaches control registers.
// RL20: the host grounds output enable to select true ide mode.
// RL21: operating mode is caught once after reset release and kept until reset.
// RL22: a pin without function in the current mode stays inactive or floating.
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH
`define PCC_CTRL_OFS     8'h00
`define PCC_STAT_OFS     8'h04
`define PCC_CTRL_RST     8'h20
`define PCC_B_IRQ        0
`define PCC_B_LEVEL      1
`define PCC_B_DMA        2
`define PCC_B_DIAG       3
`define PCC_B_ACTIVE     4
`define PCC_B_READY      5
`define PCC_B_WPROT      6
`define PCC_B_STSEN      7
`define PCC_S_SLAVE      2
`define PCC_S_CHANGED    3
`define PCC_CLK_MHZ      200
`define PCC_PULSE_NS     100
`define PCC_PULSE_CYC    ((`PCC_PULSE_NS * `PCC_CLK_MHZ + 999) / 1000)
`endif

/* File: pcc_pkg.sv */
// types shared by the pc card host pin block
package pcc_pkg;
  typedef enum logic [1:0] {
    MODE_MEM = 2'b00,
    MODE_IO  = 2'b01,
    MODE_IDE = 2'b10
  } mode_t;
  typedef enum logic [2:0] {
    SP_COMMON = 3'b000,
    SP_ATTR   = 3'b001,
    SP_IO     = 3'b010,
    SP_TASK   = 3'b011,
    SP_CTRL   = 3'b100,
    SP_DMA    = 3'b101
  } space_t;
endpackage

/* File: pcc_host_pins.sv */
// pin behaviour of a pc card / true ide flash card toward its host
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_cfg.svh"
module pcc_host_pins (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          io_strap_i,
  input  wire logic          oe_n_i,
  input  wire logic          we_n_i,
  input  wire logic          iord_n_i,
  input  wire logic          iowr_n_i,
  input  wire logic          ce1_n_i,
  input  wire logic          ce2_n_i,
  input  wire logic          reg_n_i,
  input  wire logic          cs0_n_i,
  input  wire logic          cs1_n_i,
  input  wire logic          csel_n_i,
  input  wire logic [10:0]   addr_i,
  input  wire logic [15:0]   data_i,
  output logic [15:0]        data_o,
  output logic [1:0]         data_oe_o,
  output logic               irq_pin_o,
  output logic               irq_pin_oe_o,
  output logic               inpack_dreq_o,
  output logic               inpack_dreq_oe_o,
  output logic               wait_n_o,
  output logic               wait_oe_o,
  output logic               vs1_n_o,
  output logic               vs1_oe_o,
  output logic               vs2_n_o,
  output logic               vs2_oe_o,
  output logic               bvd1_o,
  output logic               bvd1_oe_o,
  output logic               bvd2_o,
  output logic               bvd2_oe_o,
  output logic               acc_valid_o,
  output pcc_pkg::space_t    acc_space_o,
  output logic [10:0]        acc_addr_o,
  output logic               acc_write_o,
  output logic [15:0]        acc_wdata_o,
  output logic [1:0]         acc_lanes_o,
  input  wire logic          acc_done_i,
  input  wire logic [15:0]   acc_rdata_i
);
  import pcc_pkg::*;

  localparam logic [7:0] PULSE_CYC = 8'(`PCC_PULSE_CYC);

  // mode capture
  mode_t       mode_reg, mode_next;
  logic        caught_reg, caught_next;
  logic        slave_reg, slave_next;

  always_comb begin
    mode_next   = mode_reg;
    caught_next = caught_reg;
    slave_next  = slave_reg;
    // straps are sampled on the first edge after release, never under reset
    if (!caught_reg) begin
      caught_next = 1'b1; // see RL21
      if (!oe_n_i) begin
        mode_next  = MODE_IDE; // see RL20
        slave_next = csel_n_i; // see RL5
      end else begin
        mode_next  = io_strap_i ? MODE_IO : MODE_MEM;
        slave_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg   <= MODE_MEM;
      caught_reg <= 1'b0;
      slave_reg  <= 1'b0;
    end else begin
      mode_reg   <= mode_next;
      caught_reg <= caught_next;
      slave_reg  <= slave_next;
    end
  end

  wire logic ide = caught_reg && (mode_reg == MODE_IDE);
  wire logic io  = caught_reg && (mode_reg == MODE_IO);
  wire logic mem = caught_reg && (mode_reg == MODE_MEM);

  // host access decode
  logic        sel, rd, wr, strobe;
  space_t      space;
  logic [1:0]  lanes, pins;
  logic        swap;
  logic [10:0] addr;

  always_comb begin
    sel   = 1'b0;
    rd    = 1'b0;
    wr    = 1'b0;
    space = SP_COMMON;
    lanes = 2'b11;
    pins  = 2'b11;
    swap  = 1'b0;
    addr  = addr_i; // see RL11
    if (ide) begin
      sel  = !cs0_n_i || !cs1_n_i || !reg_n_i;
      rd   = !iord_n_i;
      wr   = !iowr_n_i;
      addr = {8'h00, addr_i[2:0]}; // see RL12
      if (!reg_n_i) begin
        space = SP_DMA; // see RL17
      end else if (!cs1_n_i) begin
        space = SP_CTRL; // see RL19
      end else begin
        space = SP_TASK; // see RL19
      end
      // only the data register and dma move words, the rest sits on the low lane
      if (space == SP_DMA || (space == SP_TASK && addr_i[2:0] == 3'h0)) begin
        lanes = 2'b11; // see RL10
      end else begin
        lanes = 2'b01; // see RL10
      end
      pins = lanes;
    end else if (mem || io) begin
      sel = !ce1_n_i || !ce2_n_i;
      rd  = !oe_n_i || (io && !iord_n_i);
      wr  = !we_n_i || (io && !iowr_n_i);
      if (io && (!iord_n_i || !iowr_n_i)) begin
        space = SP_IO;
      end else begin
        space = reg_n_i ? SP_COMMON : SP_ATTR; // see RL18
      end
      case ({ce2_n_i, ce1_n_i})
        2'b00: begin
          lanes = 2'b11; // see RL9
          pins  = 2'b11;
        end
        2'b01: begin
          lanes = 2'b10;
          pins  = 2'b10;
        end
        2'b10: begin
          // 8-bit hosts fetch the odd byte through the low lane
          lanes = addr_i[0] ? 2'b10 : 2'b01;
          pins  = 2'b01;
          swap  = addr_i[0];
        end
        default: begin
          lanes = 2'b00;
          pins  = 2'b00;
        end
      endcase
    end
    strobe = sel && (rd || wr);
  end

  // access sequencing toward the card core
  logic        act_reg, act_next;
  logic        pend_reg, pend_next;
  logic        valid_reg, valid_next;
  logic        isrd_reg, isrd_next;
  logic        swap_reg, swap_next;
  logic [1:0]  pins_reg, pins_next;
  logic [1:0]  lanes_reg, lanes_next;
  space_t      space_reg, space_next;
  logic [10:0] addr_reg, addr_next;
  logic [15:0] wdat_reg, wdat_next;
  logic [15:0] rdat_reg, rdat_next;

  always_comb begin
    act_next   = act_reg;
    pend_next  = pend_reg;
    valid_next = 1'b0;
    isrd_next  = isrd_reg;
    swap_next  = swap_reg;
    pins_next  = pins_reg;
    lanes_next = lanes_reg;
    space_next = space_reg;
    addr_next  = addr_reg;
    wdat_next  = wdat_reg;
    rdat_next  = rdat_reg;
    if (!act_reg && strobe) begin
      act_next   = 1'b1;
      pend_next  = 1'b1; // see RL6
      valid_next = 1'b1;
      isrd_next  = rd;
      swap_next  = swap;
      pins_next  = pins;
      lanes_next = lanes;
      space_next = space;
      addr_next  = addr;
      wdat_next  = swap ? {data_i[7:0], 8'h00} : data_i;
    end else if (act_reg && !strobe) begin
      act_next  = 1'b0;
      pend_next = 1'b0;
    end
    if (pend_reg && acc_done_i) begin
      pend_next = 1'b0;
      if (swap_reg) begin
        rdat_next = {8'h00, acc_rdata_i[15:8]}; // see RL9
      end else if (lanes_reg == 2'b01) begin
        rdat_next = {8'h00, acc_rdata_i[7:0]}; // see RL10
      end else begin
        rdat_next = acc_rdata_i; // see RL9
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_reg   <= 1'b0;
      pend_reg  <= 1'b0;
      valid_reg <= 1'b0;
      isrd_reg  <= 1'b0;
      swap_reg  <= 1'b0;
      pins_reg  <= 2'b00;
      lanes_reg <= 2'b00;
      space_reg <= SP_COMMON;
      addr_reg  <= 11'h000;
      wdat_reg  <= 16'h0000;
      rdat_reg  <= 16'h0000;
    end else begin
      act_reg   <= act_next;
      pend_reg  <= pend_next;
      valid_reg <= valid_next;
      isrd_reg  <= isrd_next;
      swap_reg  <= swap_next;
      pins_reg  <= pins_next;
      lanes_reg <= lanes_next;
      space_reg <= space_next;
      addr_reg  <= addr_next;
      wdat_reg  <= wdat_next;
      rdat_reg  <= rdat_next;
    end
  end

  // software registers and interrupt pulse
  logic [7:0]  ctrl_reg, ctrl_next;
  logic        chg_reg, chg_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdo_reg, rdo_next;
  logic        irq_q_reg, irq_q_next;
  logic [7:0]  pulse_reg, pulse_next;
  logic        wr_hit;

  always_comb begin
    ctrl_next  = ctrl_reg;
    chg_next   = chg_reg;
    ack_next   = wb_cyc_i && wb_stb_i && !ack_reg;
    rdo_next   = 32'h0000_0000;
    irq_q_next = ctrl_reg[`PCC_B_IRQ];
    pulse_next = (pulse_reg != 8'h00) ? pulse_reg - 8'h01 : 8'h00;
    // a write lands on the edge where the master sees the acknowledge
    wr_hit     = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
    if (wb_adr_i == `PCC_CTRL_OFS) begin
      rdo_next = {24'h000000, ctrl_reg};
    end else if (wb_adr_i == `PCC_STAT_OFS) begin
      rdo_next = {28'h0000000, chg_reg, slave_reg, mode_reg};
    end
    if (wr_hit && wb_adr_i == `PCC_STAT_OFS && wb_dat_i[`PCC_S_CHANGED]) begin
      chg_next = 1'b0;
    end
    if (wr_hit && wb_adr_i == `PCC_CTRL_OFS) begin
      ctrl_next = wb_dat_i[7:0];
      // set beats the clear when both land together
      if (io && (wb_dat_i[`PCC_B_READY] != ctrl_reg[`PCC_B_READY]
                 || wb_dat_i[`PCC_B_WPROT] != ctrl_reg[`PCC_B_WPROT])) begin
        chg_next = 1'b1; // see RL14
      end
    end
    if (ctrl_reg[`PCC_B_IRQ] && !irq_q_reg) begin
      pulse_next = PULSE_CYC; // see RL1
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg  <= `PCC_CTRL_RST;
      chg_reg   <= 1'b0;
      ack_reg   <= 1'b0;
      rdo_reg   <= 32'h0000_0000;
      irq_q_reg <= 1'b0;
      pulse_reg <= 8'h00;
    end else begin
      ctrl_reg  <= ctrl_next;
      chg_reg   <= chg_next;
      ack_reg   <= ack_next;
      rdo_reg   <= rdo_next;
      irq_q_reg <= irq_q_next;
      pulse_reg <= pulse_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdo_reg;

  // core-side request
  assign acc_valid_o = valid_reg;
  assign acc_space_o = space_reg;
  assign acc_addr_o  = addr_reg;
  assign acc_write_o = !isrd_reg;
  assign acc_wdata_o = wdat_reg;
  assign acc_lanes_o = lanes_reg;

  // host pins
  assign data_o    = rdat_reg;
  assign data_oe_o = (act_reg && isrd_reg && !pend_reg && strobe) ? pins_reg : 2'b00;

  always_comb begin
    irq_pin_o        = 1'b1;
    irq_pin_oe_o     = 1'b0;
    inpack_dreq_o    = 1'b1;
    inpack_dreq_oe_o = 1'b0; // see RL22
    wait_n_o         = 1'b1;
    wait_oe_o        = 1'b0;
    bvd1_o           = 1'b1;
    bvd1_oe_o        = 1'b0;
    bvd2_o           = 1'b1;
    bvd2_oe_o        = 1'b0;
    if (mem) begin
      irq_pin_o    = ctrl_reg[`PCC_B_READY];
      irq_pin_oe_o = 1'b1;
      wait_n_o     = !pend_reg; // see RL6
      wait_oe_o    = 1'b1;
      bvd1_oe_o    = 1'b1; // see RL13
      bvd2_oe_o    = 1'b1; // see RL13
    end else if (io) begin
      irq_pin_oe_o = 1'b1;
      if (ctrl_reg[`PCC_B_LEVEL]) begin
        irq_pin_o = !ctrl_reg[`PCC_B_IRQ]; // see RL1
      end else begin
        irq_pin_o = (pulse_reg == 8'h00); // see RL1
      end
      inpack_dreq_oe_o = 1'b1;
      inpack_dreq_o    = !(sel && !iord_n_i && !reg_n_i); // see RL3
      wait_n_o         = !pend_reg; // see RL6
      wait_oe_o        = 1'b1;
      bvd1_oe_o        = 1'b1;
      bvd1_o           = !(chg_reg && ctrl_reg[`PCC_B_STSEN]); // see RL14
      bvd2_oe_o        = 1'b1; // see RL13
    end else if (ide) begin
      irq_pin_oe_o     = 1'b1;
      irq_pin_o        = ctrl_reg[`PCC_B_IRQ]; // see RL2
      inpack_dreq_oe_o = 1'b1;
      inpack_dreq_o    = ctrl_reg[`PCC_B_DMA]; // see RL4
      wait_n_o         = 1'b0;
      wait_oe_o        = pend_reg; // see RL7
      // a master leaves the diagnostic line to the slave
      bvd1_o    = !ctrl_reg[`PCC_B_DIAG];
      bvd1_oe_o = slave_reg; // see RL15
      bvd2_o    = !(ctrl_reg[`PCC_B_ACTIVE] || (slave_reg && !ctrl_reg[`PCC_B_DIAG])); // see RL16
      bvd2_oe_o = 1'b1;
    end
  end

  assign vs1_n_o  = 1'b0; // see RL8
  assign vs1_oe_o = 1'b1; // see RL8
  assign vs2_n_o  = 1'b1;
  assign vs2_oe_o = 1'b0; // see RL8

endmodule // pcc_host_pins
`default_nettype wire

/* File: pcc_host_pins_monitor.sv */
// concurrent checks on the host pin block ports
`timescale 1ns/1ps
`default_nettype none
module pcc_host_pins_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        oe_n_i,
  input wire logic        iord_n_i,
  input wire logic [1:0]  data_oe_o,
  input wire logic        wait_n_o,
  input wire logic        wait_oe_o,
  input wire logic        vs1_n_o,
  input wire logic        vs1_oe_o,
  input wire logic        vs2_oe_o,
  input wire logic        acc_valid_o,
  input wire logic [10:0] acc_addr_o,
  input wire logic        acc_done_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_stall;
    !wait_n_o && wait_oe_o;
  endsequence
  a_ack_delay: assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_vs1_low: assert property (!vs1_n_o && vs1_oe_o) else $error("vs1 not low");
  a_vs2_open: assert property (!vs2_oe_o) else $error("vs2 driven");
  a_wait_start: assert property (acc_valid_o |-> s_stall) else $error("no wait");
  a_wait_hold: assert property (acc_valid_o && !acc_done_i |=> s_stall) else $error("wait dropped");
  a_wait_release: assert property (acc_done_i |=> wait_n_o || !wait_oe_o) else $error("wait stuck");
  a_valid_pulse: assert property (acc_valid_o |=> !acc_valid_o) else $error("valid too long");
  a_addr_stable: assert property (acc_valid_o |=> $stable(acc_addr_o)) else $error("addr moved");
  a_lanes_read: assert property (data_oe_o != 2'b00 |-> (!oe_n_i || !iord_n_i) && !(!wait_n_o && wait_oe_o))
    else $error("lanes driven");
endmodule // pcc_host_pins_monitor
bind pcc_host_pins pcc_host_pins_monitor i_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .oe_n_i,
  .iord_n_i, .data_oe_o, .wait_n_o, .wait_oe_o, .vs1_n_o, .vs1_oe_o, .vs2_oe_o, .acc_valid_o, .acc_addr_o,
  .acc_done_i);
`default_nettype wire

/* File: pcc_host_model.sv */
// host controller model that runs card bus cycles
`timescale 1ns/1ps
`default_nettype none
module pcc_host_model (
  input  wire logic        clk_i,
  input  wire logic        ide_i,
  input  wire logic        wait_n_i,
  input  wire logic        wait_oe_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic [1:0]  lanes_i,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic             iord_n_o,
  output logic             iowr_n_o,
  output logic             ce1_n_o,
  output logic             ce2_n_o,
  output logic             cs0_n_o,
  output logic             cs1_n_o,
  output logic             reg_n_o,
  output logic [10:0]      addr_o,
  output logic [15:0]      data_o
);
  logic [3:0]  st_n  = 4'hf;
  logic [3:0]  sel_n = 4'hf;
  logic        reg_q = 1'b1;
  logic [10:0] a_q   = 11'h000;
  logic [15:0] d_q   = 16'hffff;
  assign oe_n_o = ide_i ? 1'b0 : st_n[0];
  assign {iowr_n_o, iord_n_o, we_n_o} = st_n[3:1];
  assign {cs1_n_o, cs0_n_o, ce2_n_o, ce1_n_o} = sel_n;
  assign reg_n_o = reg_q;
  assign addr_o = a_q;
  assign data_o = d_q;
  // kind: 0 mem read, 1 mem write, 2 io read, 3 io write
  task automatic access(input logic [1:0] kind, input logic [3:0] sel, input logic rg, input logic [10:0] a,
                        input logic [15:0] d, output logic [15:0] q, output logic [1:0] ln, output logic ok);
    int n;
    @(posedge clk_i);
    sel_n <= sel;
    reg_q <= rg;
    a_q <= a;
    d_q <= d;
    st_n <= ~(4'h1 << kind);
    n = 0;
    repeat (2) @(posedge clk_i);
    // the cycle is not finished while the card stretches it, until 200 cycles have passed
    while (wait_n_i !== 1'b1 && wait_oe_i !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    q = rdata_i;
    ln = lanes_i;
    ok = n < 200;
    st_n <= 4'hf;
    sel_n <= 4'hf;
    // released lines show the inverse so stale values are not mistaken for data
    a_q <= ~a;
    d_q <= ~d;
  endtask
endmodule // pcc_host_model
`default_nettype wire

/* File: test_pcc_host_pins.sv */
// self-checking bench for the host pin block
`timescale 1ns/1ps
`default_nettype none
`include "pcc_cfg.svh"
module test_pcc_host_pins;
  import pcc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, io_strap_i = 1'b0;
  logic csel_n_i = 1'b1, acc_done_i = 1'b0, ide = 1'b0, saw_ack = 1'b0, ok;
  logic oe_n_i, we_n_i, iord_n_i, iowr_n_i, ce1_n_i, ce2_n_i, reg_n_i, cs0_n_i, cs1_n_i, wb_ack_o;
  logic irq_pin_o, irq_pin_oe_o, inpack_dreq_o, inpack_dreq_oe_o, wait_n_o, wait_oe_o, vs1_n_o, vs1_oe_o;
  logic vs2_n_o, vs2_oe_o, bvd1_o, bvd1_oe_o, bvd2_o, bvd2_oe_o, acc_valid_o, acc_write_o;
  logic [7:0]  wb_adr_i    = 8'h00;
  logic [3:0]  wb_sel_i    = 4'h1;
  logic [31:0] wb_dat_i    = 32'h0;
  logic [15:0] acc_rdata_i = 16'hb4c3;
  logic [31:0] wb_dat_o, rd;
  logic [10:0] addr_i, acc_addr_o;
  logic [15:0] data_i, data_o, acc_wdata_o, q;
  logic [1:0]  data_oe_o, acc_lanes_o, ln;
  space_t      acc_space_o;
  int          n_fail = 0, n_compared = 0, cnt = 0, k;
  pcc_host_pins i_pcc_host_pins (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .io_strap_i, .oe_n_i, .we_n_i, .iord_n_i, .iowr_n_i, .ce1_n_i, .ce2_n_i,
    .reg_n_i, .cs0_n_i, .cs1_n_i, .csel_n_i, .addr_i, .data_i, .data_o, .data_oe_o, .irq_pin_o, .irq_pin_oe_o,
    .inpack_dreq_o, .inpack_dreq_oe_o, .wait_n_o, .wait_oe_o, .vs1_n_o, .vs1_oe_o, .vs2_n_o, .vs2_oe_o,
    .bvd1_o, .bvd1_oe_o, .bvd2_o, .bvd2_oe_o, .acc_valid_o, .acc_space_o, .acc_addr_o, .acc_write_o,
    .acc_wdata_o, .acc_lanes_o, .acc_done_i, .acc_rdata_i);
  pcc_host_model i_pcc_host_model (.clk_i, .ide_i(ide), .wait_n_i(wait_n_o), .wait_oe_i(wait_oe_o),
    .rdata_i(data_o), .lanes_i(data_oe_o), .oe_n_o(oe_n_i), .we_n_o(we_n_i), .iord_n_o(iord_n_i),
    .iowr_n_o(iowr_n_i), .ce1_n_o(ce1_n_i), .ce2_n_o(ce2_n_i), .cs0_n_o(cs0_n_i), .cs1_n_o(cs1_n_i),
    .reg_n_o(reg_n_i), .addr_o(addr_i), .data_o(data_i));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // core stand-in: finishes each access three cycles after it is offered
  always @(posedge clk_i) begin
    acc_done_i <= 1'b0;
    if (acc_valid_o === 1'b1) cnt <= 3;
    else if (cnt > 0) begin
      cnt <= cnt - 1;
      acc_done_i <= cnt == 1;
    end
    if (iord_n_i === 1'b0 && inpack_dreq_oe_o === 1'b1 && inpack_dreq_o === 1'b0) saw_ack <= 1'b1;
  end
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic stuck;
    n_fail++;
    end_sim();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1) stuck();
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~d;
    // the write lands on the ack edge, so pins are looked at one edge later
    @(posedge clk_i);
  endtask
  task automatic hx(input logic [1:0] kind, input logic [3:0] sel, input logic rg, input logic [10:0] a,
                    input logic [15:0] d);
    i_pcc_host_model.access(kind, sel, rg, a, d, q, ln, ok);
    if (!ok) stuck();
  endtask
  task automatic boot(input logic io, input logic id, input logic cs);
    @(posedge clk_i);
    rst_i <= 1'b1;
    io_strap_i <= io;
    ide <= id;
    csel_n_i <= cs;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    boot(1'b0, 1'b0, 1'b1);
    wb(1'b0, `PCC_CTRL_OFS, 32'h0);
    chk("ctrl reset", `PCC_CTRL_RST, rd);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b0, `PCC_STAT_OFS, 32'h0);
    chk("status mem", 32'h0, rd);
    chk("battery pins", 4'hf, {bvd1_o, bvd1_oe_o, bvd2_o, bvd2_oe_o});
    chk("ack float", 32'h0, inpack_dreq_oe_o);
    chk("ready pin", 32'h3, {irq_pin_o, irq_pin_oe_o});
    hx(2'd0, 4'hc, 1'b1, 11'h004, 16'h0);
    chk("word read", 32'h3b4c3, {ln, q});
    chk("common", SP_COMMON, acc_space_o);
    hx(2'd0, 4'he, 1'b1, 11'h005, 16'h0);
    chk("odd byte", 32'h1b4, {ln, q[7:0]});
    chk("odd lanes", 32'h2, acc_lanes_o);
    hx(2'd0, 4'hc, 1'b0, 11'h200, 16'h0);
    chk("attr", SP_ATTR, acc_space_o);
    hx(2'd1, 4'hc, 1'b1, 11'h006, 16'h1234);
    chk("write", 32'h11234, {acc_write_o, acc_wdata_o});
    boot(1'b1, 1'b0, 1'b0);
    wb(1'b0, `PCC_STAT_OFS, 32'h0);
    chk("status io", 32'h1, rd);
    wb(1'b1, `PCC_CTRL_OFS, 32'h21);
    k = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (irq_pin_oe_o === 1'b1 && irq_pin_o === 1'b0) k++;
    end
    chk("irq pulse", `PCC_PULSE_CYC, k);
    wb(1'b1, `PCC_CTRL_OFS, 32'h23);
    repeat (30) @(posedge clk_i);
    chk("irq level", 32'h1, {irq_pin_o, irq_pin_oe_o});
    wb(1'b1, `PCC_CTRL_OFS, 32'ha0);
    wb(1'b1, `PCC_CTRL_OFS, 32'h80);
    chk("status change", 32'h7, {bvd1_o, bvd1_oe_o, bvd2_o, bvd2_oe_o});
    wb(1'b0, `PCC_STAT_OFS, 32'h0);
    chk("changed", 32'h9, rd);
    wb(1'b1, `PCC_STAT_OFS, 32'h8);
    wb(1'b0, `PCC_STAT_OFS, 32'h0);
    chk("cleared", 32'h1, rd);
    hx(2'd2, 4'hc, 1'b0, 11'h1f7, 16'h0);
    chk("input ack", 32'h1, saw_ack);
    chk("io space", SP_IO, acc_space_o);
    boot(1'b0, 1'b1, 1'b1);
    wb(1'b0, `PCC_STAT_OFS, 32'h0);
    chk("status slave", 32'h6, rd);
    hx(2'd2, 4'hb, 1'b1, 11'h7f9, 16'h0);
    chk("task file", {SP_TASK, 3'h1, 2'b01}, {acc_space_o, acc_addr_o[2:0], ln});
    hx(2'd2, 4'hb, 1'b1, 11'h000, 16'h0);
    chk("data word", 32'h3b4c3, {ln, q});
    hx(2'd2, 4'h7, 1'b1, 11'h006, 16'h0);
    chk("control", SP_CTRL, acc_space_o);
    wb(1'b1, `PCC_CTRL_OFS, 32'h25);
    chk("intrq dreq", 32'hf, {irq_pin_o, irq_pin_oe_o, inpack_dreq_o, inpack_dreq_oe_o});
    chk("wait float", 32'h0, wait_oe_o);
    chk("dasp slave", 32'h1, {bvd2_o, bvd2_oe_o});
    wb(1'b1, `PCC_CTRL_OFS, 32'h2d);
    chk("diag done", 32'h1, {bvd1_o, bvd1_oe_o});
    wb(1'b1, `PCC_CTRL_OFS, 32'h3d);
    chk("dasp active", 32'h1, {bvd2_o, bvd2_oe_o});
    boot(1'b0, 1'b1, 1'b0);
    wb(1'b0, `PCC_STAT_OFS, 32'h0);
    chk("status master", 32'h2, rd);
    end_sim();
  end
endmodule // test_pcc_host_pins
`default_nettype wire
